// ===== core/serial_poll_pkg.sv
package serial_poll_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_RATE = 19200;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam int PERIOD_UNIT_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * PERIOD_UNIT_MS;
  localparam int AUTO_TARE_S = 2;
  localparam int AUTO_TARE_CYC = CLK_HZ * AUTO_TARE_S;
  localparam int LINE_MAX = 10;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] STREAM_PERIOD_OFS = 8'h5B;
  localparam logic [15:0] STREAM_PERIOD_RST = 16'h0032;
  localparam logic [7:0] UNIT_ID_RST = 8'h41;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_C = 8'h43;
  localparam logic [7:0] CH_UP_D = 8'h44;
  localparam logic [7:0] CH_UP_P = 8'h50;
  localparam logic [7:0] CH_UP_V = 8'h56;
  localparam logic [7:0] CH_UP_W = 8'h57;
  localparam logic [7:0] CH_UP_Z = 8'h5A;
  localparam logic [5:0] FLD_BASE = 6'd2;
  localparam logic [5:0] FLD_STRIDE = 6'd7;
  localparam logic [5:0] GAS_POS = 6'd37;
  localparam logic [5:0] STAT_POS = 6'd40;
  localparam logic [5:0] FRAME_LAST = 6'd41;
  localparam logic [5:0] DESC_LEN = 6'd56;
  localparam logic [8*56-1:0] DESC_TEXT = "ID PRESS:PSIA TEMP:C VFLOW:LPM MFLOW:SLPM SETPT:SLPM GAS";
  typedef enum logic [2:0] {FMT_IDLE = 3'b001, FMT_FRAME = 3'b010, FMT_DESC = 3'b100} fmt_state_t;
endpackage : serial_poll_pkg

// ===== core/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      mem_q <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q[AW-1:0]] <= i_in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  fifo_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_in_valid && !o_in_ready) |=> $stable(wr_q))
    else $error("fifo took a word while full");
endmodule : byte_fifo
`default_nettype wire

// ===== core/uart_phy.sv
`timescale 1ns/1ps
`default_nettype none
module uart_phy #(
  parameter int DIV = 1302
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rxd,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [7:0] i_tx_data,
  output logic o_txd
);
  logic [15:0] rcnt_q;
  logic [3:0] rbit_q;
  logic rbusy_q;
  logic [7:0] rsh_q;
  logic rvalid_q;
  logic [15:0] tcnt_q;
  logic [3:0] tbit_q;
  logic tbusy_q;
  logic [9:0] tsh_q;
  logic txd_q;
  assign o_rx_valid = rvalid_q;
  assign o_rx_data = rsh_q;
  assign o_tx_ready = !tbusy_q;
  assign o_txd = txd_q;

  // Receiver: 8 data bits, no parity, stop bit must be high
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rcnt_q <= '0;
      rbit_q <= '0;
      rbusy_q <= 1'b0;
      rsh_q <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= 1'b0;
      if (!rbusy_q)
      begin
        if (!i_rxd)
        begin
          rbusy_q <= 1'b1;
          rcnt_q <= 16'(DIV / 2);
          rbit_q <= '0;
        end
      end
      else if (rcnt_q != 16'h0000)
        rcnt_q <= rcnt_q - 16'h0001;
      else
      begin
        rcnt_q <= 16'(DIV - 1);
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0)
          rbusy_q <= !i_rxd;
        else if (rbit_q < 4'h9)
          rsh_q <= {i_rxd, rsh_q[7:1]};
        else
        begin
          rbusy_q <= 1'b0;
          rvalid_q <= i_rxd;
        end
      end
    end
  end

  // Transmitter: start, 8 data LSB first, one stop
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tcnt_q <= '0;
      tbit_q <= '0;
      tbusy_q <= 1'b0;
      tsh_q <= '1;
      txd_q <= 1'b1;
    end
    else if (!tbusy_q)
    begin
      if (i_tx_valid)
      begin
        tbusy_q <= 1'b1;
        tsh_q <= {1'b1, i_tx_data, 1'b0};
        txd_q <= 1'b0;
        tbit_q <= '0;
        tcnt_q <= 16'(DIV - 1);
      end
    end
    else if (tcnt_q != 16'h0000)
      tcnt_q <= tcnt_q - 16'h0001;
    else if (tbit_q == 4'h9)
      tbusy_q <= 1'b0;
    else
    begin
      tsh_q <= {1'b1, tsh_q[9:1]};
      txd_q <= tsh_q[1];
      tbit_q <= tbit_q + 4'h1;
      tcnt_q <= 16'(DIV - 1);
    end
  end
endmodule : uart_phy
`default_nettype wire

// ===== core/ascii_serial_poll_stream.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Serial link defaults to 19200 baud, 8 data bits, no parity, one stop.
// R2: After reset the block is polling with identifier letter A.
// R3: A line holding only our identifier gets exactly one data line back while polling.
// R4: Identifier, at-sign, equals, new letter changes our identifier while polling.
// R5: Host gives each device on a port a distinct letter A to Z.
// R6: Streaming sends data lines periodically without any request.
// R7: Host puts at most one device per port into streaming.
// R8: Changing identifier to at-sign starts streaming.
// R9: Two at-signs, equals, letter leaves streaming with that letter as identifier.
// R10: Streaming lines keep going while command characters arrive.
// R11: Invalid command lines are dropped with no action and no reply.
// R12: Stream period defaults to 50 ms, register 91, written only while polling.
// R13: With auto tare on, zero setpoint held 2 s triggers one tare.
// R14: Identifier plus flow-tare command zeroes flow; host sends it with no flow.
// R15: Pressure tare aligns to barometer when fitted; host vents device first.
// R16: Data line fields are space separated in the fixed documented order.
// R17: Identifier leads the data line only in polling mode.
// R18: Identifier plus frame query returns field descriptions with units.
// R19: Extra status column may follow the gas label.
// R20: Command letters and identifiers are case-insensitive.
// R21: Commands end with carriage return and act only on it.
// R22: Numeric fields carry an explicit plus or minus sign.
module ascii_serial_poll_stream #(
  parameter int CYC_PER_MS = serial_poll_pkg::CYC_PER_MS,
  parameter int AUTO_TARE_CYC = serial_poll_pkg::AUTO_TARE_CYC,
  parameter int BAUD_DIV = serial_poll_pkg::BAUD_DIV
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic [15:0] i_abs_pressure,
  input wire logic [15:0] i_temperature,
  input wire logic [15:0] i_vol_flow,
  input wire logic [15:0] i_mass_flow,
  input wire logic [15:0] i_setpoint,
  input wire logic [15:0] i_gas_label,
  input wire logic i_status_valid,
  input wire logic [7:0] i_status_code,
  input wire logic i_has_barometer,
  input wire logic i_auto_tare_en,
  output logic o_flow_tare,
  output logic o_abs_tare,
  output logic o_stream_mode,
  output logic [7:0] o_unit_id,
  output logic [15:0] o_stream_period
);
  localparam int LM = serial_poll_pkg::LINE_MAX;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction : upcase

  function automatic logic is_digit(input logic [7:0] c);
    return c >= serial_poll_pkg::CH_ZERO && c <= 8'h39;
  endfunction : is_digit

  function automatic logic [17:0] parse_val(input logic [LM-1:0][7:0] l, input logic [3:0] n);
    logic [16:0] acc;
    logic ok;
    acc = '0;
    ok = (n > 4'd5);
    for (int i = 5; i < LM; i++)
      if (4'(i) < n)
      begin
        ok = ok & is_digit(l[i]);
        acc = 17'(acc * 17'd10 + {13'h0000, l[i][3:0]});
      end
    return {ok, acc};
  endfunction : parse_val

  function automatic logic [7:0] dec_digit(input logic [16:0] m, input logic [2:0] k);
    logic [16:0] q;
    case (k)
      3'd0: q = m;
      3'd1: q = m / 17'd10;
      3'd2: q = m / 17'd100;
      3'd3: q = m / 17'd1000;
      default: q = m / 17'd10000;
    endcase
    return serial_poll_pkg::CH_ZERO + 8'(q % 17'd10);
  endfunction : dec_digit

  logic [1:0] rst_q;
  logic [1:0] rxd_q;
  wire rst_n = rst_q[1];
  logic rx_valid;
  logic [7:0] rx_data;
  logic fifo_ready;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic [LM-1:0][7:0] line_q;
  logic [3:0] len_q;
  logic ovf_q;
  logic [7:0] id_q;
  logic stream_q;
  logic [15:0] period_q;
  logic poll_pend_q;
  logic desc_pend_q;
  logic strm_pend_q;
  logic [31:0] ms_cnt_q;
  logic [15:0] per_cnt_q;
  logic [31:0] tare_cnt_q;
  logic flow_tare_q;
  logic abs_tare_q;
  serial_poll_pkg::fmt_state_t state_q;
  logic [5:0] pos_q;
  logic [4:0][15:0] fld_q;
  logic [15:0] gas_q;
  logic stv_q;
  logic [7:0] stc_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      rxd_q <= 2'b11;
    else
      rxd_q <= {rxd_q[0], i_rxd};
  end

  // R1: fixed 8N1 framing at the default rate
  uart_phy #(.DIV(BAUD_DIV)) u_phy (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_rxd(rxd_q[1]),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data), .o_txd(o_txd)
  );

  // R11: only these forms act; any other line is dropped
  wire rx_cr = rx_valid && rx_data == serial_poll_pkg::CH_CR;
  wire id_hit = len_q != 4'd0 && !ovf_q && line_q[0] == id_q;
  wire [7:0] new_id = line_q[3];
  wire new_ok = (new_id >= serial_poll_pkg::CH_UP_A && new_id <= serial_poll_pkg::CH_UP_Z)
    || new_id == serial_poll_pkg::CH_AT;
  wire is_chid = id_hit && len_q == 4'd4 && line_q[1] == serial_poll_pkg::CH_AT
    && line_q[2] == serial_poll_pkg::CH_EQ && new_ok;
  wire is_poll = id_hit && len_q == 4'd1 && !stream_q;
  wire is_ftare = id_hit && len_q == 4'd2 && line_q[1] == serial_poll_pkg::CH_UP_V;
  wire is_ptare = id_hit && len_q == 4'd3 && line_q[1] == serial_poll_pkg::CH_UP_P
    && line_q[2] == serial_poll_pkg::CH_UP_C && i_has_barometer;
  wire is_desc = id_hit && len_q == 4'd5 && line_q[1] == serial_poll_pkg::CH_QUERY
    && line_q[2] == serial_poll_pkg::CH_QUERY && line_q[3] == serial_poll_pkg::CH_UP_D
    && line_q[4] == serial_poll_pkg::CH_STAR;
  wire [7:0] reg_num = 8'({4'h0, line_q[2][3:0]} * 8'd10) + {4'h0, line_q[3][3:0]};
  wire [17:0] wval = parse_val(line_q, len_q);
  wire is_wreg = id_hit && !stream_q && line_q[1] == serial_poll_pkg::CH_UP_W
    && is_digit(line_q[2]) && is_digit(line_q[3]) && reg_num == serial_poll_pkg::STREAM_PERIOD_OFS
    && line_q[4] == serial_poll_pkg::CH_EQ && wval[17] && !wval[16] && wval[15:0] != 16'h0000;
  // R21: act only on the terminator
  wire act_chid = rx_cr && is_chid;
  wire act_poll = rx_cr && is_poll;
  wire act_ftare = rx_cr && is_ftare;
  wire act_ptare = rx_cr && is_ptare;
  wire act_desc = rx_cr && is_desc;
  wire act_wreg = rx_cr && is_wreg;

  // R20: letters folded to upper case as stored
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_q <= '0;
      len_q <= '0;
      ovf_q <= 1'b0;
    end
    else if (rx_valid && rx_data != serial_poll_pkg::CH_LF)
    begin
      if (rx_data == serial_poll_pkg::CH_CR)
      begin
        len_q <= '0;
        ovf_q <= 1'b0;
      end
      else if (len_q == 4'(LM))
        ovf_q <= 1'b1;
      else
      begin
        line_q[len_q] <= upcase(rx_data);
        len_q <= len_q + 4'd1;
      end
    end
  end

  // R2: reset identity and polling mode
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      id_q <= serial_poll_pkg::UNIT_ID_RST;
      stream_q <= 1'b0;
      period_q <= serial_poll_pkg::STREAM_PERIOD_RST;
    end
    else
    begin
      // R4: identifier change; R8 and R9 ride on it
      if (act_chid)
      begin
        id_q <= new_id;
        stream_q <= new_id == serial_poll_pkg::CH_AT;
      end
      // R12: period register write while polling
      if (act_wreg)
        period_q <= wval[15:0];
    end
  end

  // R6: millisecond timebase and period counter
  wire ms_tick = ms_cnt_q == 32'(CYC_PER_MS - 1);
  wire per_expire = stream_q && ms_tick && ({1'b0, per_cnt_q} + 17'd1 >= {1'b0, period_q});
  wire take_desc = state_q == serial_poll_pkg::FMT_IDLE && desc_pend_q;
  wire take_frame = state_q == serial_poll_pkg::FMT_IDLE && !desc_pend_q
    && (poll_pend_q || (strm_pend_q && stream_q));
  wire sp_zero = i_auto_tare_en && i_setpoint == 16'h0000;
  wire auto_fire = sp_zero && tare_cnt_q == 32'(AUTO_TARE_CYC - 1);

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt_q <= '0;
      per_cnt_q <= '0;
      poll_pend_q <= 1'b0;
      desc_pend_q <= 1'b0;
      strm_pend_q <= 1'b0;
      tare_cnt_q <= '0;
      flow_tare_q <= 1'b0;
      abs_tare_q <= 1'b0;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 32'd1;
      // R10: period runs regardless of receive activity
      if (!stream_q || per_expire)
        per_cnt_q <= '0;
      else if (ms_tick)
        per_cnt_q <= per_cnt_q + 16'd1;
      // R3: one pending reply per poll, set wins over take
      poll_pend_q <= act_poll || (poll_pend_q && !take_frame);
      // R18: description request
      desc_pend_q <= act_desc || (desc_pend_q && !take_desc);
      // Leaving streaming drops a queued periodic line, so polling stays quiet
      strm_pend_q <= stream_q && (per_expire || (strm_pend_q && !take_frame));
      // R13: count a held zero setpoint, fire once
      if (!sp_zero)
        tare_cnt_q <= '0;
      else if (tare_cnt_q != 32'(AUTO_TARE_CYC))
        tare_cnt_q <= tare_cnt_q + 32'd1;
      // R14: flow tare pulse
      flow_tare_q <= act_ftare || auto_fire;
      // R15: pressure tare pulse, barometer only
      abs_tare_q <= act_ptare;
    end
  end

  // R16: frame character by position
  wire [5:0] rel = pos_q - serial_poll_pkg::FLD_BASE;
  wire [2:0] fidx = 3'(rel / serial_poll_pkg::FLD_STRIDE);
  wire [2:0] sub = 3'(rel % serial_poll_pkg::FLD_STRIDE);
  wire [15:0] fv = fld_q[fidx];
  wire [16:0] mag = fv[15] ? 17'h00000 - {fv[15], fv} : {1'b0, fv};
  // R22: explicit sign ahead of the digits
  wire [7:0] sign_char = fv[15] ? serial_poll_pkg::CH_MINUS : serial_poll_pkg::CH_PLUS;
  wire [7:0] fld_char = sub == 3'd0 ? sign_char
    : sub == 3'd6 ? serial_poll_pkg::CH_SP : dec_digit(mag, 3'(3'd5 - sub));
  // R19: optional status column after the gas label
  wire [7:0] tail_char = pos_q == serial_poll_pkg::GAS_POS ? gas_q[15:8]
    : pos_q == serial_poll_pkg::GAS_POS + 6'd1 ? gas_q[7:0]
    : pos_q == serial_poll_pkg::GAS_POS + 6'd2 ? (stv_q ? serial_poll_pkg::CH_SP : serial_poll_pkg::CH_CR)
    : pos_q == serial_poll_pkg::STAT_POS ? stc_q : serial_poll_pkg::CH_CR;
  wire [7:0] frame_char = pos_q == 6'd0 ? id_q : pos_q == 6'd1 ? serial_poll_pkg::CH_SP
    : pos_q < serial_poll_pkg::GAS_POS ? fld_char : tail_char;
  wire [7:0] desc_char = pos_q >= serial_poll_pkg::DESC_LEN ? serial_poll_pkg::CH_CR
    : serial_poll_pkg::DESC_TEXT[(int'(serial_poll_pkg::DESC_LEN) - 1 - int'(pos_q)) * 8 +: 8];
  wire in_desc = state_q == serial_poll_pkg::FMT_DESC;
  wire [7:0] out_char = in_desc ? desc_char : frame_char;
  wire out_valid = state_q != serial_poll_pkg::FMT_IDLE;
  wire push_ok = out_valid && fifo_ready;
  wire last_char = in_desc ? pos_q == serial_poll_pkg::DESC_LEN
    : (pos_q == serial_poll_pkg::FRAME_LAST || (pos_q == serial_poll_pkg::GAS_POS + 6'd2 && !stv_q));

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= serial_poll_pkg::FMT_IDLE;
      pos_q <= '0;
      fld_q <= '0;
      gas_q <= '0;
      stv_q <= 1'b0;
      stc_q <= '0;
    end
    else
    begin
      case (state_q)
        serial_poll_pkg::FMT_IDLE:
        begin
          if (take_desc)
          begin
            state_q <= serial_poll_pkg::FMT_DESC;
            pos_q <= '0;
          end
          else if (take_frame)
          begin
            state_q <= serial_poll_pkg::FMT_FRAME;
            // R17: streaming lines skip the identifier
            pos_q <= stream_q ? serial_poll_pkg::FLD_BASE : 6'd0;
            fld_q <= {i_setpoint, i_mass_flow, i_vol_flow, i_temperature, i_abs_pressure};
            gas_q <= i_gas_label;
            stv_q <= i_status_valid;
            stc_q <= i_status_code;
          end
        end
        serial_poll_pkg::FMT_FRAME, serial_poll_pkg::FMT_DESC:
        begin
          if (push_ok)
          begin
            if (last_char)
              state_q <= serial_poll_pkg::FMT_IDLE;
            else
              pos_q <= pos_q + 6'd1;
          end
        end
        default: state_q <= serial_poll_pkg::FMT_IDLE;
      endcase
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(serial_poll_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk), .i_rst_n(rst_n),
    .i_in_valid(out_valid), .o_in_ready(fifo_ready), .i_in_data(out_char),
    .o_out_valid(tx_valid), .i_out_ready(tx_ready), .o_out_data(tx_data)
  );

  assign o_flow_tare = flow_tare_q;
  assign o_abs_tare = abs_tare_q;
  assign o_stream_mode = stream_q;
  assign o_unit_id = id_q;
  assign o_stream_period = period_q;

  poll_reply_a: assert property ( // R3
    (take_frame && !stream_q) |=> state_q == serial_poll_pkg::FMT_FRAME && pos_q == 6'd0)
    else $error("poll did not start a full line");
  chid_take_a: assert property ( // R4
    act_chid |=> id_q == $past(new_id))
    else $error("identifier change not applied");
  stream_enter_a: assert property ( // R8
    (act_chid && new_id == serial_poll_pkg::CH_AT) |=> stream_q && o_stream_mode)
    else $error("at-sign identifier did not start streaming");
  stream_exit_a: assert property ( // R9
    (act_chid && stream_q && new_id != serial_poll_pkg::CH_AT) |=> !stream_q ##0 id_q != serial_poll_pkg::CH_AT)
    else $error("streaming did not stop");
  stream_tick_a: assert property ( // R10
    per_expire |=> strm_pend_q)
    else $error("periodic line lost");
  bad_line_a: assert property ( // R11
    (rx_cr && !(is_chid || is_poll || is_ftare || is_ptare || is_desc || is_wreg))
      |=> $stable(id_q) && $stable(period_q) && !abs_tare_q && !$rose(desc_pend_q))
    else $error("invalid line caused an action");
  period_wr_a: assert property ( // R12
    act_wreg |=> period_q == $past(wval[15:0]) && !stream_q)
    else $error("period register write wrong");
  auto_tare_a: assert property ( // R13
    auto_fire |-> i_setpoint == 16'h0000 ##1 flow_tare_q ##1 !flow_tare_q)
    else $error("auto tare pulse wrong");
  abs_tare_a: assert property ( // R15
    (rx_cr && is_ptare) |=> o_abs_tare ##1 !o_abs_tare)
    else $error("pressure tare pulse missing");
  stream_lead_a: assert property ( // R17
    (take_frame && stream_q) |=> pos_q == serial_poll_pkg::FLD_BASE)
    else $error("streaming line carries identifier");
  sign_char_a: assert property ( // R22
    (push_ok && !in_desc && pos_q >= serial_poll_pkg::FLD_BASE && pos_q < serial_poll_pkg::GAS_POS && sub == 3'd0)
      |-> out_char == serial_poll_pkg::CH_PLUS || out_char == serial_poll_pkg::CH_MINUS)
    else $error("numeric field without sign");
endmodule : ascii_serial_poll_stream
`default_nettype wire

// ===== tb/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host #(
  parameter int DIV = 8
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output var logic o_rxd
);
  logic [7:0] rxq[$];
  logic [7:0] b;
  initial o_rxd = 1'b1;
  task send_line(input string s);
    string t;
    t = {s, "\r"};
    for (int i = 0; i < t.len(); i++)
    begin
      b = t[i];
      for (int k = 0; k < 10; k++)
      begin
        @(negedge i_clk);
        o_rxd = (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k-1];
        repeat (DIV - 1) @(negedge i_clk);
      end
    end
  endtask : send_line
  always
  begin : rx_proc
    logic [7:0] r;
    @(negedge i_txd);
    repeat (DIV / 2) @(posedge i_clk);
    for (int k = 0; k < 8; k++)
    begin
      repeat (DIV) @(posedge i_clk);
      r[k] = i_txd;
    end
    repeat (DIV) @(posedge i_clk);
    if (i_txd === 1'b1)
      rxq.push_back(r);
  end
endmodule : serial_host
`default_nettype wire

// ===== tb/ascii_serial_poll_stream_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ascii_serial_poll_stream_tb;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic rxd;
  logic o_txd;
  logic o_flow_tare;
  logic o_abs_tare;
  logic o_stream_mode;
  logic [7:0] o_unit_id;
  logic [15:0] o_stream_period;
  logic [15:0] ap = 16'h04D2;
  logic [15:0] tp = 16'hFFFB;
  logic [15:0] vf = 16'h0064;
  logic [15:0] mf = 16'h7FFF;
  logic [15:0] sp = 16'h0007;
  logic [15:0] gas = 16'h4E32;
  logic [7:0] stat = 8'h58;
  logic stat_ok = 1'b1;
  logic baro = 1'b0;
  logic auto_en = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_ft = 0;
  int n_at = 0;
  string body;
  always #20 i_clk = ~i_clk;
  ascii_serial_poll_stream #(.CYC_PER_MS(10), .AUTO_TARE_CYC(40), .BAUD_DIV(8)) uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_rxd(rxd), .o_txd(o_txd),
    .i_abs_pressure(ap), .i_temperature(tp), .i_vol_flow(vf), .i_mass_flow(mf),
    .i_setpoint(sp), .i_gas_label(gas), .i_status_valid(stat_ok), .i_status_code(stat),
    .i_has_barometer(baro), .i_auto_tare_en(auto_en), .o_flow_tare(o_flow_tare),
    .o_abs_tare(o_abs_tare), .o_stream_mode(o_stream_mode), .o_unit_id(o_unit_id),
    .o_stream_period(o_stream_period)
  );
  serial_host #(.DIV(8)) host (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd));
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (o_flow_tare === 1'b1)
      n_ft <= n_ft + 1;
    if (o_abs_tare === 1'b1)
      n_at <= n_at + 1;
  end
  always @(negedge i_clk)
    if (cycles == 60000)
    begin
      err_total++;
      report_and_stop();
    end
  task report_and_stop();
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chk_line(input string exp);
    string s;
    logic [7:0] c;
    s = "";
    for (int n = 0; n < 9000; n++)
    begin
      @(posedge i_clk);
      if (host.rxq.size() > 0)
      begin
        c = host.rxq.pop_front();
        if (c == 8'h0D)
          break;
        s = {s, string'(c)};
      end
    end
    samples_checked++;
    if (s != exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, s, exp);
    end
  endtask : chk_line
  task idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask : idle
  function automatic string fld(input logic [15:0] v);
    int i;
    i = $signed(v);
    return $sformatf("%s%05d", (i < 0) ? "-" : "+", (i < 0) ? -i : i);
  endfunction : fld
  initial
  begin
    body = {fld(ap), " ", fld(tp), " ", fld(vf), " ", fld(mf), " ", fld(sp), " N2 X"};
    idle(2);
    i_rstn = 1'b1;
    idle(4);
    chk({o_stream_mode, o_unit_id}, 9'h041);
    chk(o_stream_period, 16'h0032);
    chk(o_txd, 1'b1);
    host.send_line("A");
    chk_line({"A ", body});
    host.send_line("a@=b");
    idle(20);
    chk(o_unit_id, 8'h42);
    host.send_line("a");
    host.send_line("bx9");
    idle(800);
    chk(host.rxq.size(), 0);
    host.send_line("bv");
    host.send_line("bpc");
    idle(4);
    baro = 1'b1;
    host.send_line("BPC");
    idle(20);
    chk(n_ft, 1);
    chk(n_at, 1);
    host.send_line("bw91=3");
    host.send_line("b??d*");
    chk_line("ID PRESS:PSIA TEMP:C VFLOW:LPM MFLOW:SLPM SETPT:SLPM GAS");
    chk(o_stream_period, 16'h0003);
    host.send_line("b@=@");
    idle(20);
    chk({o_stream_mode, o_unit_id}, 9'h140);
    chk_line(body);
    host.send_line("@w91=7");
    chk_line(body);
    chk(o_stream_period, 16'h0003);
    host.send_line("@@=c");
    idle(20);
    chk({o_stream_mode, o_unit_id}, 9'h043);
    idle(6000);
    host.rxq.delete();
    idle(3000);
    chk(host.rxq.size(), 0);
    stat_ok = 1'b0;
    host.send_line("c");
    chk_line({"C ", body.substr(0, body.len() - 3)});
    sp = 16'h0000;
    auto_en = 1'b1;
    idle(100);
    chk(n_ft, 2);
    report_and_stop();
  end
endmodule : ascii_serial_poll_stream_tb
`default_nettype wire
